// >>> design/rec_mask_pkg.sv
// shared constants and carrier types for the record count and mask register bank
package rec_mask_pkg;
	// byte register addresses after byte-order normalisation
	localparam logic [4:0] ADDR_RL_HIGH_LO = 5'h14;
	localparam logic [4:0] ADDR_RL_HIGH_HI = 5'h15;
	localparam logic [4:0] ADDR_RL_LOW_LO = 5'h16;
	localparam logic [4:0] ADDR_RL_LOW_HI = 5'h17;
	localparam logic [4:0] ADDR_SKIP_HIGH_LO = 5'h18;
	localparam logic [4:0] ADDR_SKIP_HIGH_HI = 5'h19;
	localparam logic [4:0] ADDR_SKIP_LOW_LO = 5'h1A;
	localparam logic [4:0] ADDR_SKIP_LOW_HI = 5'h1B;
	localparam logic [4:0] ADDR_ERROR_MASK = 5'h1C;
	localparam logic [4:0] ADDR_IRQ_MASK_LOW = 5'h1E;
	localparam logic [4:0] ADDR_IRQ_MASK_HIGH = 5'h1F;
	// reset and rollover values
	localparam logic [31:0] RL_RESET = 32'h0000_0000;
	localparam logic [31:0] RL_ROLLOVER = 32'h1000_0000;
	localparam logic [31:0] SKIP_RESET = 32'h0000_0000;
	localparam logic [7:0] MASK_RESET = 8'h00;
	// implemented bits of each mask byte
	localparam logic [7:0] ERROR_MASK_BITS = 8'h6E;
	localparam logic [7:0] IRQ_LOW_BITS = 8'hE1;
	localparam logic [7:0] IRQ_HIGH_BITS = 8'hF3;
	// error mask field positions
	localparam int SIDE_U_PARITY_MASK = 6;
	localparam int SIDE_C_PARITY_MASK = 5;
	localparam int SIDE_C_OVERFLOW_MASK = 3;
	localparam int SIDE_U_OVERFLOW_MASK = 2;
	localparam int DECODER_CODE_ERR_MASK = 1;
	// interrupt vector positions (mask high byte sits at 15:8)
	localparam int FINISHED_IRQ = 7;
	localparam int HALTED_IRQ = 6;
	localparam int SUPPRESS_END_IRQ = 5;
	localparam int FAULT_IRQ = 0;
	localparam int DECODER_REC_END_IRQ = 15;
	localparam int SIDE_C_COMPARE_IRQ = 14;
	localparam int SIDE_C_ONE_BYTE_IRQ = 13;
	localparam int SIDE_C_REC_END_IRQ = 12;
	localparam int SIDE_U_ONE_BYTE_IRQ = 9;
	localparam int SIDE_U_REC_END_IRQ = 8;
	// transfer mode codes from the command decoder
	localparam logic [2:0] XM_NONE = 3'h0;
	localparam logic [2:0] XM_COMP_BYPASS = 3'h1;
	localparam logic [2:0] XM_COMP = 3'h2;
	localparam logic [2:0] XM_DECOMP_BYPASS = 3'h3;
	localparam logic [2:0] XM_DECOMP = 3'h4;
	localparam logic [2:0] XM_DECOMP_OD = 3'h5;
	// clocks that the reset command takes to settle
	localparam logic [3:0] SOFT_RESET_CLOCKS = 4'hC;

	typedef struct packed {
		logic bus_style;
		logic [1:0] ctrl;
		logic [4:0] addr;
		logic [7:0] wdata;
	} host_req_type;

	typedef struct packed {
		logic start;
		logic resume;
		logic soft_reset;
		logic finish;
		logic [2:0] mode;
		logic u_byte;
		logic u_pad;
		logic rec_at_decoder;
	} xfer_event_type;
endpackage

// >>> design/record_len_counter.sv
// record length down-counter with host byte writes and per-record reload
`timescale 1ns/1ps
module record_len_counter import rec_mask_pkg::*; #(
	parameter int WIDTH = 32
) (
	input wire logic clk,
	input wire logic clear,
	input wire logic wr_en,
	input wire logic [1:0] wr_lane,
	input wire logic [7:0] wr_byte,
	input wire logic roll,
	input wire logic dec,
	input wire logic reload,
	output logic [WIDTH-1:0] count,
	output logic hit_zero
);
	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] shadow_reg;

	generate
		if (WIDTH != 32) begin : g_bad_width
			$error("record_len_counter needs WIDTH of 32");
		end
	endgenerate

	// one byte taken off the count reaches zero now
	assign hit_zero = dec && (count_reg == WIDTH'(1));
	assign count = count_reg;

	// host-written value kept for reload at each record end
	always_ff @(posedge clk) begin
		if (clear) begin
			shadow_reg <= RL_RESET;
		end else if (wr_en) begin
			shadow_reg[wr_lane*8 +: 8] <= wr_byte;
		end
	end

	// counter itself: clear, host write, rollover, reload, decrement
	always_ff @(posedge clk) begin
		if (clear) begin
			count_reg <= RL_RESET;
		end else if (wr_en) begin
			count_reg[wr_lane*8 +: 8] <= wr_byte;
		end else if (roll) begin
			count_reg <= RL_ROLLOVER;
		end else if (hit_zero && reload) begin
			count_reg <= shadow_reg;
		end else if (dec && count_reg != '0) begin
			count_reg <= count_reg - WIDTH'(1);
		end
	end
endmodule // record_len_counter

// >>> design/rec_mask_regs.sv
// host register bank: record length, skip count, error and interrupt masks
`timescale 1ns/1ps
module rec_mask_regs import rec_mask_pkg::*; #(
	parameter int COUNT_WIDTH = 32
) (
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire host_req_type HOST_REQ,
	output logic [7:0] HOST_DATA_OUT,
	output logic HOST_DATA_OE_N,
	output logic HOST_WAIT_N,
	output logic HOST_WAIT_OE_N,
	output logic IRQ_REQUEST_N,
	input wire xfer_event_type XFER_EVT,
	input wire logic [31:0] RECORD_COUNT,
	input wire logic [7:0] ERR_STATUS,
	input wire logic [15:0] IRQ_PENDING,
	output logic SIDE_U_REC_END,
	output logic XFER_TOTAL_DONE,
	output logic SIDE_U_OUTPUT_DISABLE,
	output logic SUPPRESS_END,
	output logic ANY_FAULT_FLAG,
	output logic FAULT_IRQ_SET
);
	typedef enum logic [0:0] {RUN_IDLE, RUN_ACTIVE} run_state_type;

	run_state_type run_reg;
	logic [2:0] mode_reg;
	logic [31:0] skip_reg;
	logic [31:0] seen_reg;
	logic [7:0] error_report_mask_reg;
	logic [7:0] imsk_low_reg;
	logic [7:0] imsk_high_reg;
	logic [3:0] settle_reg;
	logic [7:0] rdata_reg;
	logic rd_act_reg;
	logic wr_act_reg;
	logic irq_n_reg;
	logic rec_end_reg;
	logic total_done_reg;
	logic od_reg;
	logic supp_end_reg;
	logic fault_reg;
	logic fault_set_reg;
	logic cs;
	logic rd_act;
	logic wr_act;
	logic wr_pulse;
	logic [4:0] eff_addr;
	logic clear;
	logic [31:0] count;
	logic hit_zero;
	logic rl_wr;
	logic count_mode;
	logic dec;
	logic roll;
	logic od_active;
	logic od_whole;
	logic fault_now;
	logic [15:0] irq_vec;

	generate
		if (COUNT_WIDTH != 32) begin : g_bad_width
			$error("rec_mask_regs needs COUNT_WIDTH of 32");
		end
	endgenerate

	// style high swaps the byte pair so one map serves both orders
	function automatic logic [4:0] norm_addr(input logic style, input logic [4:0] a);
		norm_addr = style ? {a[4:1], ~a[0]} : a;
	endfunction

	// byte lane of a 32-bit counter addressed by a normalised address
	function automatic logic [1:0] lane_of(input logic [4:0] a);
		lane_of = {~a[1], a[0]};
	endfunction

	// strobe decode for both bus styles
	always_comb begin
		if (HOST_REQ.bus_style) begin
			cs = ~HOST_REQ.ctrl[0];
			rd_act = cs && HOST_REQ.ctrl[1];
			wr_act = cs && !HOST_REQ.ctrl[1];
		end else begin
			rd_act = ~HOST_REQ.ctrl[0];
			wr_act = ~HOST_REQ.ctrl[1];
			cs = rd_act || wr_act;
		end
	end

	// one write per strobe, held off while a reset command settles
	assign wr_pulse = wr_act && !wr_act_reg && (settle_reg == 4'h0);
	assign eff_addr = norm_addr(HOST_REQ.bus_style, HOST_REQ.addr);
	assign clear = RESET || XFER_EVT.soft_reset;
	assign rl_wr = wr_pulse && eff_addr[4:2] == ADDR_RL_HIGH_LO[4:2];

	// strobe history for edge detection and read data timing
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			rd_act_reg <= 1'b0;
			wr_act_reg <= 1'b0;
		end else begin
			rd_act_reg <= rd_act;
			wr_act_reg <= wr_act;
		end
	end

	// reset command settle timer
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			settle_reg <= 4'h0;
		end else if (XFER_EVT.soft_reset) begin
			settle_reg <= SOFT_RESET_CLOCKS;
		end else if (settle_reg != 4'h0) begin
			settle_reg <= settle_reg - 4'h1;
		end
	end

	// transfer tracking
	always_ff @(posedge CORE_CLK) begin
		if (clear) begin
			run_reg <= RUN_IDLE;
			mode_reg <= XM_NONE;
		end else begin
			case (run_reg)
				RUN_IDLE: begin
					if (XFER_EVT.start) begin
						run_reg <= RUN_ACTIVE;
						mode_reg <= XFER_EVT.mode;
					end
				end
				RUN_ACTIVE: begin
					if (XFER_EVT.finish) begin
						run_reg <= RUN_IDLE;
						mode_reg <= XM_NONE;
					end else if (XFER_EVT.start) begin
						mode_reg <= XFER_EVT.mode;
					end
				end
				default: run_reg <= RUN_IDLE;
			endcase
		end
	end

	// record length counts only in compression, compression bypass and decompression bypass
	assign count_mode = run_reg == RUN_ACTIVE &&
		(mode_reg == XM_COMP || mode_reg == XM_COMP_BYPASS || mode_reg == XM_DECOMP_BYPASS);
	assign dec = count_mode && XFER_EVT.u_byte && !XFER_EVT.u_pad;
	assign roll = (XFER_EVT.start || XFER_EVT.resume) && count == RL_RESET;

	record_len_counter #(
		.WIDTH(COUNT_WIDTH)
	) u_rl (
		.clk(CORE_CLK),
		.clear(clear),
		.wr_en(rl_wr),
		.wr_lane(lane_of(eff_addr)),
		.wr_byte(HOST_REQ.wdata),
		.roll(roll),
		.dec(dec),
		.reload(mode_reg != XM_DECOMP_BYPASS),
		.count(count),
		.hit_zero(hit_zero)
	);

	// record end per record, or whole transfer in decompression bypass
	always_ff @(posedge CORE_CLK) begin
		if (clear) begin
			rec_end_reg <= 1'b0;
			total_done_reg <= 1'b0;
		end else begin
			rec_end_reg <= hit_zero && mode_reg != XM_DECOMP_BYPASS;
			total_done_reg <= hit_zero && mode_reg == XM_DECOMP_BYPASS;
		end
	end

	// skip count register, host byte writes
	always_ff @(posedge CORE_CLK) begin
		if (clear) begin
			skip_reg <= SKIP_RESET;
		end else if (wr_pulse && eff_addr[4:2] == ADDR_SKIP_HIGH_LO[4:2]) begin
			skip_reg[lane_of(eff_addr)*8 +: 8] <= HOST_REQ.wdata;
		end
	end

	// output suppression during output-disabled decompression
	assign od_active = run_reg == RUN_ACTIVE && mode_reg == XM_DECOMP_OD;
	assign od_whole = skip_reg == SKIP_RESET || skip_reg > RECORD_COUNT;

	always_ff @(posedge CORE_CLK) begin
		if (clear || XFER_EVT.start) begin
			seen_reg <= 32'h0000_0000;
		end else if (od_active && XFER_EVT.rec_at_decoder && seen_reg < skip_reg) begin
			seen_reg <= seen_reg + 32'h0000_0001;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (clear) begin
			od_reg <= 1'b0;
			supp_end_reg <= 1'b0;
		end else begin
			od_reg <= od_active && (od_whole || seen_reg < skip_reg);
			supp_end_reg <= od_active && !od_whole && XFER_EVT.rec_at_decoder &&
				seen_reg + 32'h0000_0001 == skip_reg;
		end
	end

	// mask registers; reserved bits never store
	always_ff @(posedge CORE_CLK) begin
		if (clear) begin
			error_report_mask_reg <= MASK_RESET;
			imsk_low_reg <= MASK_RESET;
			imsk_high_reg <= MASK_RESET;
		end else if (wr_pulse) begin
			case (eff_addr)
				ADDR_ERROR_MASK: error_report_mask_reg <= HOST_REQ.wdata & ERROR_MASK_BITS;
				ADDR_IRQ_MASK_LOW: imsk_low_reg <= HOST_REQ.wdata & IRQ_LOW_BITS;
				ADDR_IRQ_MASK_HIGH: imsk_high_reg <= HOST_REQ.wdata & IRQ_HIGH_BITS;
				default: ;
			endcase
		end
	end

	// unmasked errors raise the any-fault flag and fault interrupt
	assign fault_now = |(ERR_STATUS & ERROR_MASK_BITS & ~error_report_mask_reg);

	always_ff @(posedge CORE_CLK) begin
		if (clear) begin
			fault_reg <= 1'b0;
			fault_set_reg <= 1'b0;
		end else begin
			fault_reg <= fault_now;
			fault_set_reg <= fault_now && !fault_reg;
		end
	end

	// interrupt request pin gated by both mask bytes
	assign irq_vec = {IRQ_PENDING[15:1], IRQ_PENDING[FAULT_IRQ] || fault_reg} &
		~{imsk_high_reg, imsk_low_reg} &
		{IRQ_HIGH_BITS, IRQ_LOW_BITS};

	always_ff @(posedge CORE_CLK) begin
		if (clear) begin
			irq_n_reg <= 1'b1;
		end else begin
			irq_n_reg <= ~|irq_vec;
		end
	end

	// read data path
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			rdata_reg <= 8'h00;
		end else if (rd_act) begin
			case (eff_addr)
				ADDR_RL_HIGH_LO, ADDR_RL_HIGH_HI, ADDR_RL_LOW_LO, ADDR_RL_LOW_HI:
					rdata_reg <= count[lane_of(eff_addr)*8 +: 8];
				ADDR_SKIP_HIGH_LO, ADDR_SKIP_HIGH_HI, ADDR_SKIP_LOW_LO, ADDR_SKIP_LOW_HI:
					rdata_reg <= skip_reg[lane_of(eff_addr)*8 +: 8];
				ADDR_ERROR_MASK: rdata_reg <= error_report_mask_reg;
				ADDR_IRQ_MASK_LOW: rdata_reg <= imsk_low_reg;
				ADDR_IRQ_MASK_HIGH: rdata_reg <= imsk_high_reg;
				default: rdata_reg <= 8'h00;
			endcase
		end
	end

	// bus pins: data driven once read data is registered, wait held low until then
	assign HOST_DATA_OUT = rdata_reg;
	assign HOST_DATA_OE_N = !(rd_act && rd_act_reg);
	assign HOST_WAIT_N = !(rd_act && !rd_act_reg);
	assign HOST_WAIT_OE_N = !cs;
	assign IRQ_REQUEST_N = irq_n_reg;
	assign SIDE_U_REC_END = rec_end_reg;
	assign XFER_TOTAL_DONE = total_done_reg;
	assign SIDE_U_OUTPUT_DISABLE = od_reg;
	assign SUPPRESS_END = supp_end_reg;
	assign ANY_FAULT_FLAG = fault_reg;
	assign FAULT_IRQ_SET = fault_set_reg;

	// checks
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RESET);

	logic quiet;
	assign quiet = !rl_wr && !XFER_EVT.start && !XFER_EVT.resume && !XFER_EVT.soft_reset;

	AST_IRQ_RESET: assert property (disable iff (1'b0) RESET |=> IRQ_REQUEST_N)
		else $error("interrupt pin not inactive after reset");
	AST_RL_DEC: assert property (quiet && dec && count > 32'h1 |=> count == $past(count) - 32'h1)
		else $error("record length did not decrement");
	AST_REC_END: assert property (quiet && dec && count == 32'h1 && mode_reg == XM_COMP
		|=> SIDE_U_REC_END)
		else $error("record end not flagged");
	AST_PAD_SKIP: assert property (quiet && XFER_EVT.u_pad |=> $stable(count))
		else $error("pad byte counted");
	AST_ROLLOVER: assert property (!XFER_EVT.soft_reset && !rl_wr && XFER_EVT.start && count == 32'h0
		|=> count == RL_ROLLOVER)
		else $error("no rollover load");
	AST_NO_COUNT: assert property (quiet && run_reg == RUN_ACTIVE && mode_reg >= XM_DECOMP
		|=> $stable(count))
		else $error("record length moved in decompression");
	AST_SOFT_CLEAR: assert property (XFER_EVT.soft_reset
		|=> error_report_mask_reg == 8'h00 && imsk_low_reg == 8'h00 && imsk_high_reg == 8'h00 && count == 32'h0
		&& skip_reg == 32'h0)
		else $error("reset command left a register set");
	AST_IRQ_GATE: assert property ($fell(IRQ_REQUEST_N) |-> $past(|irq_vec))
		else $error("interrupt pin without unmasked source");
	AST_RESERVED: assert property (((error_report_mask_reg & ~ERROR_MASK_BITS) | (imsk_low_reg & ~IRQ_LOW_BITS)
		| (imsk_high_reg & ~IRQ_HIGH_BITS)) == 8'h00)
		else $error("reserved mask bit set");
	AST_OD_WHOLE: assert property (od_active && skip_reg == 32'h0 && !XFER_EVT.finish && !XFER_EVT.soft_reset
		|=> SIDE_U_OUTPUT_DISABLE)
		else $error("output not suppressed");
	AST_WAIT_RELEASE: assert property (!cs |-> HOST_WAIT_OE_N)
		else $error("wait driven without chip select");
	AST_ANY_FAULT: assert property (fault_now && !XFER_EVT.soft_reset |=> ANY_FAULT_FLAG ##1 !FAULT_IRQ_SET)
		else $error("unmasked error not reported");

	COV_MASK_WRITE: cover property (wr_pulse && eff_addr == ADDR_ERROR_MASK);
	COV_REC_END: cover property (SIDE_U_REC_END);
	COV_IRQ: cover property ($fell(IRQ_REQUEST_N));
	COV_SUPPRESS_END: cover property (SUPPRESS_END);
endmodule // rec_mask_regs

// >>> sim/host_model.sv
// host microprocessor model that drives the eight-bit register bus
`timescale 1ns/1ps
module host_model import rec_mask_pkg::*; (
	input wire logic clk,
	input wire logic [7:0] data_in,
	input wire logic data_oe_n,
	input wire logic wait_val,
	input wire logic wait_oe_n,
	output host_req_type req
);
	logic wait_pin;
	// wait line as the host sees it, pulled up when released
	assign wait_pin = wait_oe_n ? 1'b1 : wait_val;
	// bus idle at time zero: no strobe, no chip select
	initial begin
		req = '{bus_style: 1'b0, ctrl: 2'b11, addr: 5'h00, wdata: 8'h00};
	end
	// byte-lane address swap of the high style
	function automatic logic [4:0] map_addr(input logic style, input logic [4:0] a);
		return style ? (a ^ 5'h01) : a;
	endfunction
	// one write: strobe for one clock, then an idle clock so strobes never abut
	task automatic write_byte(input logic style, input logic [4:0] a, input logic [7:0] d);
		req <= '{bus_style: style, ctrl: (style ? 2'b00 : 2'b01), addr: map_addr(style, a), wdata: d};
		@(posedge clk);
		req.ctrl <= 2'b11;
		req.wdata <= ~d; // released lines carry no stale value
		@(posedge clk);
	endtask
	// one read: hold the strobe for two clocks, sample data and wait, then release and idle
	task automatic read_byte(input logic style, input logic [4:0] a, output logic [7:0] d, output logic [1:0] hs);
		req <= '{bus_style: style, ctrl: 2'b10, addr: map_addr(style, a), wdata: req.wdata};
		#1;
		hs[1] = wait_pin;
		@(posedge clk);
		@(posedge clk);
		d = data_in;
		hs[0] = data_oe_n | ~wait_pin;
		req.ctrl <= 2'b11;
		@(posedge clk);
	endtask
endmodule // host_model

// >>> sim/tb.sv
// self-checking testbench for the record count and mask register bank
`timescale 1ns/1ps
module tb import rec_mask_pkg::*;;
	typedef struct {logic [4:0] a; logic [7:0] d; logic [7:0] e;} row_type;
	localparam int EV_START = 0, EV_RESUME = 1, EV_SOFT = 2, EV_FINISH = 3, EV_BYTE = 4, EV_PAD = 5, EV_REC = 6;
	logic clk = 1'b0;
	logic rst = 1'b1;
	host_req_type req;
	xfer_event_type evt = '0;
	logic [31:0] rec_count = 32'h0000_0001;
	logic [7:0] err_st = 8'h00;
	logic [15:0] irq_pend = 16'h0000;
	logic [7:0] rdata;
	logic data_oe_n, wait_val, wait_oe_n, irq_n, rec_end, total_done, out_dis, sup_end, any_fault, fault_set;
	int bad_count = 0;
	int n_compared = 0;
	int rec_end_n = 0;
	int total_n = 0;
	int sup_n = 0;
	int fault_n = 0;
	row_type rows[12] = '{'{5'h14, 8'hA5, 8'hA5}, '{5'h15, 8'h5A, 8'h5A}, '{5'h16, 8'hC3, 8'hC3},
		'{5'h17, 8'h3C, 8'h3C}, '{5'h18, 8'h81, 8'h81}, '{5'h19, 8'h42, 8'h42}, '{5'h1A, 8'h24, 8'h24},
		'{5'h1B, 8'h18, 8'h18}, '{5'h1C, 8'hFF, 8'h6E}, '{5'h1E, 8'hFF, 8'hE1}, '{5'h1F, 8'hFF, 8'hF3},
		'{5'h1D, 8'hFF, 8'h00}};
	logic [2:0] cmodes[2] = '{XM_COMP_BYPASS, XM_COMP};
	logic [2:0] dmodes[2] = '{XM_DECOMP, XM_DECOMP_OD};
	logic [7:0] skips[2] = '{8'h00, 8'h09};

	// clock generator
	always #5 clk = ~clk;

	rec_mask_regs #(.COUNT_WIDTH(32)) u_rec_mask_regs (.CORE_CLK(clk), .RESET(rst), .HOST_REQ(req),
		.HOST_DATA_OUT(rdata), .HOST_DATA_OE_N(data_oe_n), .HOST_WAIT_N(wait_val), .HOST_WAIT_OE_N(wait_oe_n),
		.IRQ_REQUEST_N(irq_n), .XFER_EVT(evt), .RECORD_COUNT(rec_count), .ERR_STATUS(err_st),
		.IRQ_PENDING(irq_pend), .SIDE_U_REC_END(rec_end), .XFER_TOTAL_DONE(total_done),
		.SIDE_U_OUTPUT_DISABLE(out_dis), .SUPPRESS_END(sup_end), .ANY_FAULT_FLAG(any_fault),
		.FAULT_IRQ_SET(fault_set));
	host_model u_host_model (.clk(clk), .data_in(rdata), .data_oe_n(data_oe_n), .wait_val(wait_val),
		.wait_oe_n(wait_oe_n), .req(req));

	// count the one-cycle pulses of the bank
	always @(posedge clk) begin
		if (rec_end === 1'b1) rec_end_n++;
		if (total_done === 1'b1) total_n++;
		if (sup_end === 1'b1) sup_n++;
		if (fault_set === 1'b1) fault_n++;
	end

	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic end_test(input string name);
		$display("test %s done", name);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		u_host_model.write_byte(1'b0, a, d);
	endtask
	// read in the given style (low by default) and compare data, wait and data enable
	task automatic rd(input logic [4:0] a, input logic [7:0] exp, input logic style = 1'b0);
		logic [7:0] d;
		logic [1:0] hs;
		u_host_model.read_byte(style, a, d, hs);
		check("read data", {24'h0, d}, {24'h0, exp});
		check("read handshake", {30'h0, hs}, 32'h0);
		check("wait released", {31'h0, wait_oe_n}, 32'h1);
	endtask
	// one event pulse from the command decoder, then a quiet clock
	task automatic fire(input int k, input logic [2:0] m = XM_NONE);
		xfer_event_type e;
		e = '0;
		case (k)
			EV_START: e.start = 1'b1;
			EV_RESUME: e.resume = 1'b1;
			EV_SOFT: e.soft_reset = 1'b1;
			EV_FINISH: e.finish = 1'b1;
			EV_BYTE: e.u_byte = 1'b1;
			EV_PAD: e = '{u_byte: 1'b1, u_pad: 1'b1, default: '0};
			default: e.rec_at_decoder = 1'b1;
		endcase
		e.mode = m;
		evt <= e;
		@(posedge clk);
		evt <= '0;
		@(posedge clk);
	endtask

	// watchdog against a hung handshake
	initial begin
		#100000;
		bad_count++;
		$display("watchdog expired");
		tally_and_finish();
	end

	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		foreach (rows[i]) rd(rows[i].a, 8'h00);
		end_test("reset values");
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e);
		end
		end_test("register rows");
		// hardware reset with no transfer running and an unmasked interrupt pending
		irq_pend <= 16'h0001;
		rst <= 1'b1;
		settle(3);
		check("irq pin in reset", {31'h0, irq_n}, 32'h1);
		rst <= 1'b0;
		irq_pend <= 16'h0000;
		settle(1);
		foreach (rows[i]) rd(rows[i].a, 8'h00);
		end_test("hardware reset");
		// reset command, then a write inside the hold-off that must be dropped
		foreach (rows[i]) wr(rows[i].a, rows[i].d);
		fire(EV_SOFT);
		wr(ADDR_ERROR_MASK, 8'h6E);
		foreach (rows[i]) rd(rows[i].a, 8'h00);
		settle(12);
		end_test("reset command");
		// high style: chip select with read-not-write, swapped byte lanes
		u_host_model.write_byte(1'b1, ADDR_RL_LOW_LO, 8'h77);
		rd(ADDR_RL_LOW_LO, 8'h77);
		rd(ADDR_RL_LOW_LO, 8'h77, 1'b1);
		u_host_model.write_byte(1'b1, ADDR_IRQ_MASK_LOW, 8'hFF);
		rd(ADDR_IRQ_MASK_LOW, 8'hE1);
		wr(ADDR_IRQ_MASK_LOW, 8'h00);
		end_test("bus style");
		// compression modes: per-record count, pads skipped, reload at record end
		foreach (cmodes[i]) begin
			rec_end_n = 0;
			wr(ADDR_RL_LOW_LO, 8'h02);
			fire(EV_START, cmodes[i]);
			fire(EV_PAD);
			fire(EV_BYTE);
			rd(ADDR_RL_LOW_LO, 8'h01);
			fire(EV_BYTE);
			settle(2);
			check("record end pulses", rec_end_n, 1);
			rd(ADDR_RL_LOW_LO, 8'h02);
			fire(EV_FINISH);
		end
		end_test("record length");
		total_n = 0;
		rec_end_n = 0;
		fire(EV_START, XM_DECOMP_BYPASS);
		fire(EV_BYTE);
		fire(EV_BYTE);
		settle(2);
		check("total done pulses", total_n, 1);
		check("record end pulses", rec_end_n, 0);
		fire(EV_FINISH);
		foreach (dmodes[i]) begin
			wr(ADDR_RL_LOW_LO, 8'h02);
			fire(EV_START, dmodes[i]);
			fire(EV_BYTE);
			fire(EV_BYTE);
			rd(ADDR_RL_LOW_LO, 8'h02);
			fire(EV_FINISH);
		end
		end_test("decompression modes");
		wr(ADDR_RL_LOW_LO, 8'h00);
		fire(EV_START, XM_COMP);
		rd(ADDR_RL_HIGH_HI, 8'h10);
		fire(EV_FINISH);
		wr(ADDR_RL_HIGH_HI, 8'h00);
		fire(EV_RESUME);
		rd(ADDR_RL_HIGH_HI, 8'h10);
		fire(EV_FINISH);
		end_test("rollover");
		// skipped records; record count is now large enough for several records
		rec_count <= 32'h0000_0005;
		sup_n = 0;
		wr(ADDR_SKIP_LOW_LO, 8'h02);
		fire(EV_START, XM_DECOMP_OD);
		settle(1);
		check("output disabled", {31'h0, out_dis}, 32'h1);
		fire(EV_REC);
		fire(EV_REC);
		settle(1);
		check("suppress end pulses", sup_n, 1);
		check("output disabled", {31'h0, out_dis}, 32'h0);
		fire(EV_FINISH);
		foreach (skips[i]) begin
			wr(ADDR_SKIP_LOW_LO, skips[i]);
			fire(EV_START, XM_DECOMP_OD);
			fire(EV_REC);
			fire(EV_REC);
			settle(1);
			check("output disabled", {31'h0, out_dis}, 32'h1);
			fire(EV_FINISH);
		end
		end_test("skip count");
		// error masking and interrupt pin masking
		fault_n = 0;
		err_st <= 8'h40;
		settle(3);
		check("any fault", {31'h0, any_fault}, 32'h1);
		check("fault irq pulses", fault_n, 1);
		check("irq pin", {31'h0, irq_n}, 32'h0);
		wr(ADDR_ERROR_MASK, 8'h40);
		settle(3);
		check("any fault", {31'h0, any_fault}, 32'h0);
		check("irq pin", {31'h0, irq_n}, 32'h1);
		err_st <= 8'h00;
		irq_pend <= 16'h0100;
		settle(3);
		check("irq pin", {31'h0, irq_n}, 32'h0);
		wr(ADDR_IRQ_MASK_HIGH, 8'h01);
		settle(2);
		check("irq pin", {31'h0, irq_n}, 32'h1);
		irq_pend <= 16'h0080;
		settle(2);
		check("irq pin", {31'h0, irq_n}, 32'h0);
		wr(ADDR_IRQ_MASK_LOW, 8'h80);
		settle(2);
		check("irq pin", {31'h0, irq_n}, 32'h1);
		end_test("masks");
		tally_and_finish();
	end
endmodule // tb
